// [emb_consts.vh]
// constants for the external memory bus port
`ifndef EMB_CONSTS_VH
`define EMB_CONSTS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define EMB_CLK_PERIOD_NS 10
`define EMB_ISA_STROBE_NS 100
`define EMB_ISA_STROBE_CYC ((`EMB_ISA_STROBE_NS + `EMB_CLK_PERIOD_NS - 1) / `EMB_CLK_PERIOD_NS)
`define EMB_ASYNC_TIMEOUT_CYC 255
`define EMB_DRAM_TRCD_CYC 2
`define EMB_DRAM_CAS_LAT 2
`define EMB_DRAM_COL_BITS 9
`define EMB_DRAM_AP_BIT 10

// ----------------------------------------
// address decode on core address bits 31:28
// ----------------------------------------
`define EMB_REGION_DRAM1 4'h0
`define EMB_REGION_DRAM2 4'h1
`define EMB_REGION_CS0 4'h4
`define EMB_REGION_CS1 4'h5
`define EMB_REGION_ISA1 4'h8
`define EMB_REGION_ISA2 4'h9

// ----------------------------------------
// targets
// ----------------------------------------
`define EMB_TGT_DRAM1 3'h0
`define EMB_TGT_DRAM2 3'h1
`define EMB_TGT_CS0 3'h2
`define EMB_TGT_CS1 3'h3
`define EMB_TGT_ISA1 3'h4
`define EMB_TGT_ISA2 3'h5
`define EMB_TGT_DEFAULT 3'h6

// ----------------------------------------
// port width select bits
// ----------------------------------------
`define EMB_W_CS0 0
`define EMB_W_CS1 1
`define EMB_W_ISA1 2
`define EMB_W_ISA2 3
`define EMB_W_DEFAULT 4

// ----------------------------------------
// dual function pins
// ----------------------------------------
`define EMB_NDUAL 9
`define EMB_P_A25 0
`define EMB_P_DRAM_EN2 1
`define EMB_P_ASYNC1 2
`define EMB_P_ISA1_RD 3
`define EMB_P_ISA1_WR 4
`define EMB_P_ISA2_RD 5
`define EMB_P_ISA2_WR 6
`define EMB_P_BUF1 7
`define EMB_P_BUF2 8

`endif

// [emb_pin_mux.v]
// one dual function pin: primary output or general purpose i/o
`timescale 1ns/1ps
module emb_pin_mux
(
   input wire clk,
   input wire rst_n,
   input wire prim_out,
   input wire gpio_sel,
   input wire gpio_out,
   input wire gpio_drive,
   input wire pin_in,
   output wire pin_out,
   output wire pin_oe_n,
   output wire gpio_in
);
   reg sel;
   reg sync1;
   reg sync2;

   // ----------------------------------------
   // select and input path
   // ----------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel <= 1'b0;
         sync1 <= 1'b0;
         sync2 <= 1'b0;
      end
      else
      begin
         sel <= gpio_sel;
         sync1 <= pin_in;
         sync2 <= sync1;
      end
   end

   assign pin_out = sel ? gpio_out : prim_out;
   assign pin_oe_n = sel ? ~gpio_drive : 1'b0;
   assign gpio_in = sync2;
endmodule

// [emb_bus_port.v]
// external memory bus port: sdram, async chip selects, isa peripherals
`timescale 1ns/1ps
`include "emb_consts.vh"

// Notes on behaviour
// - address lines carry byte or msb address
// - provide A23..A1 plus A25
// - address lines mux dram row, column
// - read/write low on writes, high reads
// - output enable low in async and isa read cycles
// - 16-bit data bus, read sampled rising edge
// - per target port width, default otherwise
// - writes drive all 16 data lines
// - 16-bit sdram only, 64 Mbyte
// - active low row, column strobes
// - dram write low writes, high reads
// - two dram enables, second gpio capable
// - upper and lower byte masks
// - clock enable high, dram clocked by bus
// - two chip selects, second gpio capable
// - two isa peripherals, read/write strobes
// - isa ready low inserts wait states
// - two bus buffer steering outputs
// - gpio input always shows pin
// - function select picks gpio or primary
// - dual pins primary after reset
module emb_bus_port
#(
   parameter TRCD_CYC = `EMB_DRAM_TRCD_CYC,
   parameter CAS_LAT = `EMB_DRAM_CAS_LAT,
   parameter COL_BITS = `EMB_DRAM_COL_BITS,
   parameter AP_BIT = `EMB_DRAM_AP_BIT,
   parameter ASYNC_TIMEOUT = `EMB_ASYNC_TIMEOUT_CYC,
   parameter ISA_STROBE_CYC = `EMB_ISA_STROBE_CYC
)
(
   input wire REF_CLK,
   input wire RST_N,
   input wire REQ_VALID,
   output wire REQ_READY,
   input wire REQ_WRITE,
   input wire REQ_WORD,
   input wire [31:0] REQ_ADDR,
   input wire [15:0] REQ_WDATA,
   output reg RSP_VALID,
   output reg [15:0] RSP_RDATA,
   input wire [4:0] WIDTH16,
   output wire [22:0] ADDR,
   output wire RW_N,
   output wire OE_N,
   input wire [15:0] DATA_IN,
   output reg [15:0] DATA_OUT,
   output wire DATA_OE_N,
   output wire DRAM_ROW_STROBE_N,
   output wire DRAM_COLUMN_STROBE_N,
   output wire DRAM_WRITE_N,
   output wire DRAM_ENABLE_1_N,
   output wire DRAM_UPPER_MASK,
   output wire DRAM_LOWER_MASK,
   output reg DRAM_CLOCK_EN,
   output wire DRAM_CLK,
   output wire ASYNC_SELECT_0_N,
   input wire TRANSFER_ACK_N,
   input wire ISA_READY_IN,
   output wire TRANSFER_ACK_GPI,
   output wire ISA_READY_GPI,
   input wire [8:0] DUAL_PIN_IN,
   output wire [8:0] DUAL_PIN_OUT,
   output wire [8:0] DUAL_PIN_OE_N,
   input wire [8:0] GPIO_SEL,
   input wire [8:0] GPIO_OUT,
   input wire [8:0] GPIO_DRIVE,
   output wire [8:0] GPIO_IN
);
   localparam S_IDLE = 3'h0;
   localparam S_ACT = 3'h1;
   localparam S_RCD = 3'h2;
   localparam S_CAS = 3'h3;
   localparam S_LAT = 3'h4;
   localparam S_ASYNC = 3'h5;
   localparam S_ISA = 3'h6;

   reg [2:0] state;
   reg [2:0] tgt;
   reg [31:0] req_addr;
   reg req_write;
   reg req_word;
   reg [15:0] req_wdata;
   reg beat;
   reg [7:0] cnt;
   reg [24:0] addr_pins;
   reg [15:0] data_s1;
   reg [15:0] data_s2;
   reg ta_s1;
   reg ta_s2;
   reg rdy_s1;
   reg rdy_s2;
   reg [2:0] next_tgt;
   reg next_narrow;
   reg narrow;

   wire idle = (state == S_IDLE);
   wire is_dram = (tgt == `EMB_TGT_DRAM1) || (tgt == `EMB_TGT_DRAM2);
   wire s_word = idle ? REQ_WORD : req_word;
   wire [15:0] s_wdata = idle ? REQ_WDATA : req_wdata;
   wire [25:0] s_base = idle ? REQ_ADDR[25:0] : req_addr[25:0];
   // msb byte first, then next byte
   wire [25:0] beat_addr = s_base + {25'h0, ~idle};
   wire s_narrow = idle ? next_narrow : narrow;
   wire [7:0] wr_byte = (!s_word || (s_narrow && idle)) ? 
                        (s_word ? s_wdata[15:8] : s_wdata[7:0]) : s_wdata[7:0];
   wire [15:0] beat_data = (s_word && !s_narrow) ? s_wdata : {wr_byte, wr_byte};
   wire last_beat = !(req_word && narrow) || beat;
   wire [7:0] rd_byte = (narrow || !req_addr[0]) ? data_s2[15:8] : data_s2[7:0];
   wire [24:0] row_addr = req_addr[25:1] >> COL_BITS;
   wire [24:0] col_mask = (25'h1 << COL_BITS) - 25'h1;
   wire [24:0] col_addr = (req_addr[25:1] & col_mask) | (25'h1 << AP_BIT);
   wire [8:0] prim;

   // ----------------------------------------
   // address decode and port width
   // ----------------------------------------
   always @*
   begin
      next_tgt = `EMB_TGT_DEFAULT;
      next_narrow = !WIDTH16[`EMB_W_DEFAULT];
      case (REQ_ADDR[31:28])
         `EMB_REGION_DRAM1:
         begin
            next_tgt = `EMB_TGT_DRAM1;
            next_narrow = 1'b0;
         end
         `EMB_REGION_DRAM2:
         begin
            next_tgt = `EMB_TGT_DRAM2;
            next_narrow = 1'b0;
         end
         `EMB_REGION_CS0:
         begin
            next_tgt = `EMB_TGT_CS0;
            next_narrow = !WIDTH16[`EMB_W_CS0];
         end
         `EMB_REGION_CS1:
         begin
            next_tgt = `EMB_TGT_CS1;
            next_narrow = !WIDTH16[`EMB_W_CS1];
         end
         `EMB_REGION_ISA1:
         begin
            next_tgt = `EMB_TGT_ISA1;
            next_narrow = !WIDTH16[`EMB_W_ISA1];
         end
         `EMB_REGION_ISA2:
         begin
            next_tgt = `EMB_TGT_ISA2;
            next_narrow = !WIDTH16[`EMB_W_ISA2];
         end
         default:
         begin
            next_tgt = `EMB_TGT_DEFAULT;
            next_narrow = !WIDTH16[`EMB_W_DEFAULT];
         end
      endcase
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         data_s1 <= 16'h0000;
         data_s2 <= 16'h0000;
         ta_s1 <= 1'b0;
         ta_s2 <= 1'b0;
         rdy_s1 <= 1'b0;
         rdy_s2 <= 1'b0;
         DRAM_CLOCK_EN <= 1'b0;
      end
      else
      begin
         // read data taken on rising edge
         data_s1 <= DATA_IN;
         data_s2 <= data_s1;
         ta_s1 <= ~TRANSFER_ACK_N;
         ta_s2 <= ta_s1;
         rdy_s1 <= ISA_READY_IN;
         rdy_s2 <= rdy_s1;
         DRAM_CLOCK_EN <= 1'b1;
      end
   end

   // ----------------------------------------
   // bus cycle sequencer
   // ----------------------------------------
   always @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state <= S_IDLE;
         tgt <= `EMB_TGT_DEFAULT;
         req_addr <= 32'h00000000;
         req_write <= 1'b0;
         req_word <= 1'b0;
         req_wdata <= 16'h0000;
         narrow <= 1'b0;
         beat <= 1'b0;
         cnt <= 8'h00;
         addr_pins <= 25'h0000000;
         DATA_OUT <= 16'h0000;
         RSP_VALID <= 1'b0;
         RSP_RDATA <= 16'h0000;
      end
      else
      begin
         RSP_VALID <= 1'b0;
         cnt <= cnt + 8'h01;
         case (state)
            S_IDLE:
            begin
               if (REQ_VALID)
               begin
                  req_addr <= REQ_ADDR;
                  req_write <= REQ_WRITE;
                  req_word <= REQ_WORD;
                  req_wdata <= REQ_WDATA;
                  tgt <= next_tgt;
                  narrow <= next_narrow;
                  beat <= 1'b0;
                  cnt <= 8'h00;
                  // all 16 lines carry write data
                  DATA_OUT <= beat_data;
                  if ((next_tgt == `EMB_TGT_DRAM1) || (next_tgt == `EMB_TGT_DRAM2))
                  begin
                     addr_pins <= REQ_ADDR[25:1] >> COL_BITS;
                     state <= S_ACT;
                  end
                  else
                  begin
                     addr_pins <= beat_addr[25:1];
                     if ((next_tgt == `EMB_TGT_ISA1) || (next_tgt == `EMB_TGT_ISA2))
                        state <= S_ISA;
                     else
                        state <= S_ASYNC;
                  end
               end
            end
            S_ACT:
            begin
               addr_pins <= row_addr;
               cnt <= 8'h00;
               state <= S_RCD;
            end
            S_RCD:
            begin
               if (cnt >= TRCD_CYC - 1)
               begin
                  addr_pins <= col_addr;
                  state <= S_CAS;
               end
            end
            S_CAS:
            begin
               cnt <= 8'h00;
               if (req_write)
               begin
                  RSP_VALID <= 1'b1;
                  state <= S_IDLE;
               end
               else
                  state <= S_LAT;
            end
            S_LAT:
            begin
               // latency plus two synchroniser stages
               if (cnt >= CAS_LAT + 1)
               begin
                  RSP_RDATA <= req_word ? data_s2 : {8'h00, rd_byte};
                  RSP_VALID <= 1'b1;
                  state <= S_IDLE;
               end
            end
            default:
            begin
               // wait while isa ready low
               // stale acknowledge of the previous cycle ignored
               if (((state == S_ASYNC) && ((ta_s2 && (cnt >= 8'h02)) ||
                                           (cnt >= ASYNC_TIMEOUT - 1))) ||
                   ((state == S_ISA) && (cnt >= ISA_STROBE_CYC - 1) && rdy_s2))
               begin
                  cnt <= 8'h00;
                  if (!req_word)
                     RSP_RDATA <= {8'h00, rd_byte};
                  else if (!narrow)
                     RSP_RDATA <= data_s2;
                  else if (!beat)
                     RSP_RDATA[15:8] <= data_s2[15:8];
                  else
                     RSP_RDATA[7:0] <= data_s2[15:8];
                  if (last_beat)
                  begin
                     RSP_VALID <= 1'b1;
                     state <= S_IDLE;
                  end
                  else
                  begin
                     // narrow port: second byte follows at once
                     beat <= 1'b1;
                     addr_pins <= beat_addr[25:1];
                     DATA_OUT <= beat_data;
                  end
               end
               else if (cnt == 8'hff)
                  cnt <= cnt;
            end
         endcase
      end
   end

   // ----------------------------------------
   // pin decode
   // ----------------------------------------
   // decoded from registered state; strobes change only on clock edges
   assign REQ_READY = idle;
   assign ADDR = addr_pins[22:0];
   assign RW_N = idle | ~req_write;
   assign OE_N = ~(~req_write && ((state == S_ASYNC) || (state == S_ISA)));
   assign DATA_OE_N = ~(req_write && ((state == S_CAS) || (state == S_ASYNC) ||
                                      (state == S_ISA)));
   // one cycle row and column commands
   assign DRAM_ROW_STROBE_N = ~(state == S_ACT);
   assign DRAM_COLUMN_STROBE_N = ~(state == S_CAS);
   // write low only in write command
   assign DRAM_WRITE_N = ~((state == S_CAS) && req_write);
   assign DRAM_ENABLE_1_N = ~(((state == S_ACT) || (state == S_CAS)) &&
                              (tgt == `EMB_TGT_DRAM1));
   assign DRAM_UPPER_MASK = is_dram & ~req_word & req_addr[0];
   assign DRAM_LOWER_MASK = is_dram & ~req_word & ~req_addr[0];
   assign DRAM_CLK = REF_CLK;
   assign ASYNC_SELECT_0_N = ~((state == S_ASYNC) && (tgt == `EMB_TGT_CS0));
   assign TRANSFER_ACK_GPI = ~ta_s2;
   assign ISA_READY_GPI = rdy_s2;

   assign prim[`EMB_P_A25] = addr_pins[24];
   assign prim[`EMB_P_DRAM_EN2] = ~(((state == S_ACT) || (state == S_CAS)) &&
                                   (tgt == `EMB_TGT_DRAM2));
   assign prim[`EMB_P_ASYNC1] = ~((state == S_ASYNC) && (tgt == `EMB_TGT_CS1));
   assign prim[`EMB_P_ISA1_RD] = ~((state == S_ISA) && (tgt == `EMB_TGT_ISA1) && ~req_write);
   assign prim[`EMB_P_ISA1_WR] = ~((state == S_ISA) && (tgt == `EMB_TGT_ISA1) && req_write);
   assign prim[`EMB_P_ISA2_RD] = ~((state == S_ISA) && (tgt == `EMB_TGT_ISA2) && ~req_write);
   assign prim[`EMB_P_ISA2_WR] = ~((state == S_ISA) && (tgt == `EMB_TGT_ISA2) && req_write);
   // buffer 1 async and isa, 2 dram
   assign prim[`EMB_P_BUF1] = (state == S_ASYNC) || (state == S_ISA);
   assign prim[`EMB_P_BUF2] = ~idle && is_dram;

   // ----------------------------------------
   // dual function pins
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < `EMB_NDUAL; i = i + 1)
      begin : g_pin
         emb_pin_mux u_pin
         (
            .clk(REF_CLK),
            .rst_n(RST_N),
            .prim_out(prim[i]),
            .gpio_sel(GPIO_SEL[i]),
            .gpio_out(GPIO_OUT[i]),
            .gpio_drive(GPIO_DRIVE[i]),
            .pin_in(DUAL_PIN_IN[i]),
            .pin_out(DUAL_PIN_OUT[i]),
            .pin_oe_n(DUAL_PIN_OE_N[i]),
            .gpio_in(GPIO_IN[i])
         );
      end
   endgenerate
endmodule

// [emb_bus_port_monitor.sv]
// pin level checker for the external memory bus port
`timescale 1ns/1ps
module emb_bus_port_monitor
#(
   parameter TRCD_CYC = 2
)
(
   input logic REF_CLK,
   input logic RST_N,
   input logic REQ_READY,
   input logic RSP_VALID,
   input logic RW_N,
   input logic OE_N,
   input logic DATA_OE_N,
   input logic DRAM_ROW_STROBE_N,
   input logic DRAM_COLUMN_STROBE_N,
   input logic DRAM_WRITE_N,
   input logic DRAM_CLOCK_EN,
   input logic ASYNC_SELECT_0_N,
   input logic TRANSFER_ACK_N,
   input logic ISA_READY_GPI,
   input logic [8:0] DUAL_PIN_IN,
   input logic [8:0] DUAL_PIN_OUT,
   input logic [8:0] DUAL_PIN_OE_N,
   input logic [8:0] GPIO_SEL,
   input logic [8:0] GPIO_IN
);
   localparam int ACT2CAS = TRCD_CYC + 1;
   default clocking mon_cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);
   // ----------------------------------------
   // dram command steps
   // ----------------------------------------
   sequence act_s;
      !DRAM_ROW_STROBE_N && DRAM_COLUMN_STROBE_N;
   endsequence
   sequence cas_s;
      DRAM_ROW_STROBE_N && !DRAM_COLUMN_STROBE_N;
   endsequence
   act_to_cas_a: assert property (act_s |-> ##ACT2CAS cas_s)
      else $error("column strobe not after row delay");
   write_rw_a: assert property (!DATA_OE_N |-> !RW_N)
      else $error("data driven outside write");
   read_oe_a: assert property (!OE_N |-> RW_N)
      else $error("output enable in write");
   dram_we_a: assert property (!DRAM_WRITE_N |-> (!RW_N and cas_s))
      else $error("dram write outside write command");
   ack_end_a: assert property ($fell(TRANSFER_ACK_N) && !ASYNC_SELECT_0_N |-> ##3 RSP_VALID)
      else $error("acknowledge did not end cycle");
   isa_hold_a: assert property (!ISA_READY_GPI && DUAL_PIN_OUT[6:3] != 4'hf |=> !RSP_VALID)
      else $error("isa cycle ended while not ready");
   steer_idle_a: assert property (REQ_READY && GPIO_SEL[8:7] == 2'b00
      && $past(GPIO_SEL[8:7]) == 2'b00 |-> DUAL_PIN_OUT[8:7] == 2'b00)
      else $error("buffer steered while idle");
   clock_en_a: assert property (RST_N |=> DRAM_CLOCK_EN)
      else $error("dram clock enable low");
   gpio_in_a: assert property ($past(RST_N) && $past(RST_N, 2)
      |-> GPIO_IN == $past(DUAL_PIN_IN, 2))
      else $error("gpio input not following pin");
   prim_pin_a: assert property (GPIO_SEL == 9'h000 && $past(GPIO_SEL) == 9'h000
      |-> DUAL_PIN_OE_N == 9'h000)
      else $error("primary pin not driven");
endmodule
bind emb_bus_port emb_bus_port_monitor #(.TRCD_CYC(TRCD_CYC)) u_mon
(
   .REF_CLK(REF_CLK), .RST_N(RST_N), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
   .RW_N(RW_N), .OE_N(OE_N), .DATA_OE_N(DATA_OE_N), .DRAM_ROW_STROBE_N(DRAM_ROW_STROBE_N),
   .DRAM_COLUMN_STROBE_N(DRAM_COLUMN_STROBE_N), .DRAM_WRITE_N(DRAM_WRITE_N),
   .DRAM_CLOCK_EN(DRAM_CLOCK_EN), .ASYNC_SELECT_0_N(ASYNC_SELECT_0_N),
   .TRANSFER_ACK_N(TRANSFER_ACK_N), .ISA_READY_GPI(ISA_READY_GPI), .DUAL_PIN_IN(DUAL_PIN_IN),
   .DUAL_PIN_OUT(DUAL_PIN_OUT), .DUAL_PIN_OE_N(DUAL_PIN_OE_N), .GPIO_SEL(GPIO_SEL),
   .GPIO_IN(GPIO_IN)
);

// [emb_far_model.sv]
// far side model: async memories, isa peripherals, sdram read data
`timescale 1ns/1ps
module emb_far_model
#(
   parameter CAS_LAT = 2
)
(
   input wire clk,
   input wire [22:0] addr,
   input wire oe_n,
   input wire [1:0] cs_n,
   input wire [3:0] isa_n,
   input wire cas_n,
   input wire we_n,
   input wire [7:0] ack_wait,
   input wire [7:0] isa_wait,
   output reg [15:0] dq,
   output reg ack_n,
   output reg ready
);
   reg [7:0] acnt = 8'h00;
   reg [7:0] icnt = 8'h00;
   reg [3:0] lat = 4'h0;
   reg [22:0] col = 23'h000000;
   initial
   begin
      dq = 16'h0000;
      ack_n = 1'b1;
      ready = 1'b1;
   end
   always @(posedge clk)
   begin
      acnt <= (cs_n != 2'b11) ? acnt + 8'h01 : 8'h00;
      icnt <= (isa_n != 4'hf) ? icnt + 8'h01 : 8'h00;
      ack_n <= (cs_n == 2'b11) || acnt < ack_wait || acnt > ack_wait + 8'h02;
      ready <= (isa_n == 4'hf) || icnt >= isa_wait;
      if (!cas_n && we_n)
      begin
         col <= addr;
         lat <= CAS_LAT + 4;
      end
      else if (lat != 4'h0)
         lat <= lat - 4'h1;
      // released bus toggles, so stale data never matches
      if (!oe_n)
         dq <= addr[15:0] ^ 16'h5a3c;
      else if (lat != 4'h0)
         dq <= col[15:0] ^ 16'h5a3c;
      else
         dq <= ~dq;
   end
endmodule

// [emb_bus_port_tb_top.sv]
// self-checking bench for the external memory bus port
`timescale 1ns/1ps
module emb_bus_port_tb_top;
   localparam int TMO = 40;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg req_valid = 1'b0, req_write = 1'b0, req_word = 1'b0;
   reg [31:0] req_addr = 32'h0;
   reg [15:0] req_wdata = 16'h0;
   reg [4:0] width16 = 5'h1f;
   reg [8:0] gpio_sel = 9'h0, gpio_out = 9'h0, gpio_drive = 9'h0, ext_pin = 9'h0;
   reg [7:0] ack_wait = 8'd6, isa_wait = 8'd15;
   wire req_ready, rsp_valid, rw_n, oe_n, data_oe_n, ras_n, cas_n, dwe_n, en1_n;
   wire umask, lmask, cke, cs0_n, ack_n, ready, tack_gpi, dclk;
   wire [15:0] rsp_rdata, data_in, data_out;
   wire [22:0] addr;
   wire [8:0] pin_in, pin_out, pin_oe_n, gpio_in;
   integer error_cnt = 0, num_checks = 0, cyc;
   reg got, s_rw0, s_oe, s_cs0, s_cs1, s_b1, s_b2, s_en1, s_en2, s_we, s_um, s_lm;
   reg [3:0] s_str;
   reg [23:0] s_a;
   reg [22:0] s_row, s_col;
   reg [15:0] s_dout;
   always #5 clk = ~clk;
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_pin & pin_oe_n);
   emb_bus_port #(.ASYNC_TIMEOUT(TMO)) DUT
   (
      .REF_CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_READY(req_ready),
      .REQ_WRITE(req_write), .REQ_WORD(req_word), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
      .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .WIDTH16(width16), .ADDR(addr),
      .RW_N(rw_n), .OE_N(oe_n), .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE_N(data_oe_n),
      .DRAM_ROW_STROBE_N(ras_n), .DRAM_COLUMN_STROBE_N(cas_n), .DRAM_WRITE_N(dwe_n),
      .DRAM_ENABLE_1_N(en1_n), .DRAM_UPPER_MASK(umask), .DRAM_LOWER_MASK(lmask),
      .DRAM_CLOCK_EN(cke), .DRAM_CLK(dclk), .ASYNC_SELECT_0_N(cs0_n), .TRANSFER_ACK_N(ack_n),
      .ISA_READY_IN(ready), .TRANSFER_ACK_GPI(tack_gpi), .ISA_READY_GPI(), .DUAL_PIN_IN(pin_in),
      .DUAL_PIN_OUT(pin_out), .DUAL_PIN_OE_N(pin_oe_n), .GPIO_SEL(gpio_sel),
      .GPIO_OUT(gpio_out), .GPIO_DRIVE(gpio_drive), .GPIO_IN(gpio_in)
   );
   emb_far_model FAR
   (
      .clk(clk), .addr(addr), .oe_n(oe_n), .cs_n({pin_out[2], cs0_n}), .isa_n(pin_out[6:3]),
      .cas_n(cas_n), .we_n(dwe_n), .ack_wait(ack_wait), .isa_wait(isa_wait), .dq(data_in),
      .ack_n(ack_n), .ready(ready)
   );
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string what, input [31:0] exp, input [31:0] seen);
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic req(input w, input wd, input [31:0] a, input [15:0] d);
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_word <= wd;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk);
      req_valid <= 1'b0;
      {got, s_rw0, s_oe, s_cs0, s_cs1, s_b1, s_b2, s_en1, s_en2, s_str} = 0;
      cyc = 0;
      while (!got && cyc < 400)
      begin
         @(negedge clk);
         cyc = cyc + 1;
         s_rw0 = s_rw0 | !rw_n;
         s_oe = s_oe | !oe_n;
         s_cs0 = s_cs0 | !cs0_n;
         s_cs1 = s_cs1 | !pin_out[2];
         s_b1 = s_b1 | pin_out[7];
         s_b2 = s_b2 | pin_out[8];
         s_en1 = s_en1 | !en1_n;
         s_en2 = s_en2 | !pin_out[1];
         s_str = s_str | ~pin_out[6:3];
         if (!oe_n || !cs0_n || !data_oe_n)
            s_a = {pin_out[0], addr};
         if (!data_oe_n)
            s_dout = data_out;
         if (!ras_n)
            s_row = addr;
         if (!cas_n)
            {s_col, s_we, s_um, s_lm} = {addr, !dwe_n, umask, lmask};
         got = (rsp_valid === 1'b1);
      end
      chk("response", 1, got);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_async;
      reg [31:0] a = 32'h4200_0246;
      req(0, 1, a, 16'h0000);
      chk("rdata", a[16:1] ^ 16'h5a3c, rsp_rdata);
      chk("addr", a[23:1], s_a[22:0]);
      chk("a25", a[25], s_a[23]);
      chk("cs0 oe rw0", 3'b110, {s_cs0, s_oe, s_rw0});
      chk("steer", 2'b01, {s_b2, s_b1});
      ack_wait <= 8'd1;
      req(1, 1, 32'h5000_0100, 16'hbeef);
      chk("wdata", 16'hbeef, s_dout);
      chk("cs1 oe rw0", 3'b101, {s_cs1, s_oe, s_rw0});
      @(posedge clk);
      width16 <= 5'h1e;
      a = 32'h4000_0021;
      req(0, 0, a, 16'h0000);
      chk("narrow rdata", {8'h00, a[16:9] ^ 8'h5a}, rsp_rdata);
      req(1, 0, a, 16'h005a);
      chk("lanes", 16'h5a5a, s_dout);
      @(posedge clk);
      width16 <= 5'h1f;
      req(0, 1, 32'h2000_0008, 16'h0000);
      chk("timeout", 1, cyc >= TMO);
      chk("default sel", 4'b0011, {s_cs0, s_cs1, s_oe, s_b1});
      $display("test async done");
   endtask
   task automatic test_dram;
      reg [31:0] a = 32'h0000_2468;
      req(1, 1, a, 16'h1357);
      chk("write len", 5, cyc);
      chk("row", a[25:1] >> 9, s_row);
      chk("col", 23'h400 | a[9:1], s_col);
      chk("dram wdata", 16'h1357, s_dout);
      chk("we en steer", 5'b11100, {s_we, s_en1, s_b2, s_b1, s_oe});
      chk("word mask", 2'b00, {s_um, s_lm});
      req(1, 0, a, 16'h0077);
      chk("even mask", 2'b01, {s_um, s_lm});
      req(1, 0, a + 1, 16'h0077);
      chk("odd mask", 2'b10, {s_um, s_lm});
      a = 32'h1000_0abc;
      req(0, 1, a, 16'h0000);
      chk("dram rdata", (16'h400 | a[9:1]) ^ 16'h5a3c, rsp_rdata);
      chk("read we en2", 2'b01, {s_we, s_en2});
      $display("test dram done");
   endtask
   task automatic test_isa;
      reg [31:0] a;
      for (int p = 0; p < 2; p++)
         for (int w = 0; w < 2; w++)
         begin
            a = {4'h8 + p[3:0], 28'h0000040};
            req(w[0], 1, a, 16'h2c4b);
            chk("strobe", 4'h1 << (2 * p + w), s_str);
            chk("wait", 1, cyc > isa_wait);
            if (w == 0)
               chk("isa rdata", a[16:1] ^ 16'h5a3c, rsp_rdata);
         end
      $display("test isa done");
   endtask
   task automatic test_gpio;
      @(posedge clk);
      gpio_sel <= 9'h004;
      gpio_drive <= 9'h004;
      repeat (3) @(negedge clk);
      chk("gpio out", 2'b00, {pin_out[2], pin_oe_n[2]});
      @(posedge clk);
      gpio_drive <= 9'h000;
      ext_pin <= 9'h004;
      repeat (4) @(negedge clk);
      chk("gpio in", 3'b110, {gpio_in[2], pin_oe_n[2], gpio_in[7]});
      @(posedge clk);
      rst_n <= 1'b0;
      @(negedge clk);
      chk("reset primary", 0, pin_oe_n);
      @(posedge clk);
      rst_n <= 1'b1;
      gpio_sel <= 9'h000;
      repeat (3) @(negedge clk);
      chk("after reset", 4'b1110, {req_ready, cke, tack_gpi, dclk});
      $display("test gpio done");
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(negedge clk);
      chk("idle pins", 13'h1001, {req_ready, pin_oe_n, pin_out[8:7], cke});
      test_async;
      test_dram;
      test_isa;
      test_gpio;
      conclude;
   end
   // all scenarios need well under 2000 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt = error_cnt + 1;
      conclude;
   end
endmodule
